// *** hw/lds_pkg.sv ***
// Purpose: shared constants and carrier types of the lcd reset and supply control block
// Assumes: 32-bit apb data, one 8-bit register per aligned word
// Notes:   register index times four gives the byte address
package lds_pkg;

    // ------------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------------
    localparam int unsigned NUM_CFG          = 17;      // configuration registers 0..16
    localparam int unsigned IDX_CTRL         = 0;       // supply, amplifier, display on
    localparam int unsigned IDX_MODE         = 1;       // duty, grey mode, partial mode
    localparam int unsigned IDX_SCAN         = 2;       // blink, column reverse, address step
    localparam int unsigned IDX_XADDR        = 3;       // x address counter
    localparam int unsigned IDX_YADDR        = 4;       // y address counter
    localparam int unsigned IDX_PARTIAL_WIN  = 11;      // partial_window_reg
    localparam int unsigned IDX_CONTRAST_ALT = 16;      // contrast_alternation_reg
    localparam int unsigned IDX_RAM_DATA     = 17;      // display ram data window
    localparam int unsigned IDX_STATUS       = 18;      // read-only block state
    localparam int unsigned IDX_LAST         = 18;      // highest mapped index

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_SUPPLY_ON   = 0;       // supply_on_bit
    localparam int unsigned CTRL_LEVEL_BUF   = 1;       // level_buffer_enable_bit
    localparam int unsigned CTRL_DISP_ON     = 2;       // display on
    localparam int unsigned MODE_DUTY_LSB    = 0;       // two-bit duty code, 0 = 1/80
    localparam int unsigned MODE_GREY4       = 2;       // 0 = 32-level, 1 = 4-level
    localparam int unsigned MODE_PARTIAL     = 3;       // partial display mode
    localparam int unsigned SCAN_BLINK_ON    = 0;       // blink_on_bit
    localparam int unsigned SCAN_COL_REV     = 1;       // column mapping reversed
    localparam int unsigned SCAN_X_STEP      = 2;       // 0 = step y, 1 = step x
    localparam int unsigned CA_CONTRAST_LSB  = 0;       // three contrast bits
    localparam int unsigned CA_ALT_LSB       = 3;       // two alternation cycle bits
    localparam int unsigned CA_BIAS_LSB      = 5;       // two bias select bits

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] CFG_CLEAR         = 8'h00;   // registers 0..11 and 16
    localparam logic [7:0] DEF_R12           = 8'h00;   // plain default
    localparam logic [7:0] DEF_R13           = 8'h00;   // plain default
    localparam logic [7:0] DEF_R14           = 8'h00;   // plain default
    localparam logic [7:0] DEF_R15           = 8'h00;   // plain default

    // ------------------------------------------------------------------
    // panel geometry and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] Y_LAST            = 8'h4f;   // 80 rows
    localparam logic [7:0] X_LAST            = 8'h27;   // 40 bytes of 4 pixels
    localparam int unsigned CLK_PERIOD_NS    = 25;      // 40 MHz system clock
    localparam int unsigned HAZARD_NS        = 200;     // strobe-to-fetch hazard window
    localparam int unsigned HAZARD_CYC_RAW   = HAZARD_NS / CLK_PERIOD_NS;
    localparam int unsigned HAZARD_CYC       = (HAZARD_CYC_RAW < 1) ? 1 : HAZARD_CYC_RAW;

    // bias codes seen by the level generator
    localparam logic [2:0] BIAS_6            = 3'h0;
    localparam logic [2:0] BIAS_7            = 3'h1;
    localparam logic [2:0] BIAS_8            = 3'h2;
    localparam logic [2:0] BIAS_9            = 3'h3;
    localparam logic [2:0] BIAS_4            = 3'h4;

    // panel drive carrier
    typedef struct packed {
        logic       blank;      // all outputs at the common off level
        logic       polarity;   // alternation phase
        logic       partial;    // partial display active
        logic [2:0] bias;       // bias code
        logic [2:0] contrast;   // contrast level
        logic [6:0] line;       // current scan line
    } lds_panel_t;

endpackage : lds_pkg

// *** hw/lds_ctrl.sv ***
// Purpose: reset, supply and drive-level control of a grey-scale lcd driver, apb register access
// Assumes: SYS_CLK at 40 MHz, RESETN asynchronous active low from a pin
// Notes:   panel outputs are control levels; analog levels are generated outside this logic
//
// Operation
// - reset clears all configuration registers
// - host strobes ignored while in reset
// - registers 0-11,16 zero; 12-15 defaults
// - oscillator runs, fine grey clock selected
// - blink off, display off, amplifiers off
// - address counters zero, vertical auto-increment
// - ram address zero on first column
// - alternation once per frame after reset
// - reset forces outputs off, no alternation
// - partial mode uses quarter bias
// - three low contrast bits pick level
// - bias one-sixth to one-ninth selectable
// - supply enable pin follows supply bit
// - late host strobe may cause stray line
// - stray line never corrupts stored data
// - oscillator follows grey mode automatically
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module lds_ctrl #(
    parameter int unsigned FINE_LINE_DIV   = 64,   // system cycles per line, 32-level mode
    parameter int unsigned COARSE_LINE_DIV = 640   // system cycles per line, slow clock modes
) (
    // clock and reset
    input  wire logic               SYS_CLK,
    input  wire logic               RESETN,
    // apb slave
    input  wire logic               PSEL,
    input  wire logic               PENABLE,
    input  wire logic               PWRITE,
    input  wire logic [7:0]         PADDR,
    input  wire logic [31:0]        PWDATA,
    output var  logic [31:0]        PRDATA,
    output var  logic               PREADY,
    output var  logic               PSLVERR,
    // supply and level generator
    output var  logic               EXT_SUPPLY_ENABLE_OUT,
    output var  logic               LEVEL_BUFFER_ENABLE,
    output var  logic               FINE_GREY_OSC_SELECT,
    // panel drive
    output var  lds_pkg::lds_panel_t PANEL,
    output var  logic               DISPLAY_ON,
    output var  logic               BLINK_ACTIVE,
    output var  logic               COLUMN_REVERSED,
    output var  logic               STRAY_LINE
);

    // ------------------------------------------------------------------
    // reset release synchroniser
    // ------------------------------------------------------------------
    logic rst_meta;      // first stage, read only by rst_sync
    logic rst_sync;      // released reset, high when running

    // two stages so the release never lands mid-cycle on the logic below
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic [5:0] idx;         // word index
    logic       mapped;      // aligned and in range
    logic       setup_ph;    // setup cycle
    logic       access_ph;   // access cycle
    logic       wr_en;       // write takes effect
    logic       ram_touch;   // host access to display ram window

    function automatic logic [7:0] reset_value(input int unsigned i);
        unique case (i)
            12:      return lds_pkg::DEF_R12;
            13:      return lds_pkg::DEF_R13;
            14:      return lds_pkg::DEF_R14;
            15:      return lds_pkg::DEF_R15;
            default: return lds_pkg::CFG_CLEAR;
        endcase
    endfunction : reset_value

    assign idx       = PADDR[7:2];
    assign mapped    = (PADDR[1:0] == 2'h0) && (idx <= 6'(lds_pkg::IDX_LAST));
    assign setup_ph  = PSEL && !PENABLE;
    assign access_ph = PSEL && PENABLE;
    // strobes are dropped until the synchronised release
    assign wr_en     = access_ph && PWRITE && mapped && rst_sync;
    assign ram_touch = access_ph && mapped && rst_sync && (idx == 6'(lds_pkg::IDX_RAM_DATA));
    // zero wait states: read data is captured in the setup cycle
    assign PREADY    = 1'b1;
    assign PSLVERR   = access_ph && !mapped;

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    logic [7:0] cfg      [lds_pkg::NUM_CFG];   // registers 0..16
    logic [7:0] next_cfg [lds_pkg::NUM_CFG];
    logic [7:0] ram_word;                      // last word through the ram window
    logic [7:0] next_ram_word;
    logic       x_step;                        // address step selects x

    assign x_step = cfg[lds_pkg::IDX_SCAN][lds_pkg::SCAN_X_STEP];

    // writes and the automatic address step
    always_comb begin
        for (int i = 0; i < lds_pkg::NUM_CFG; i++) begin
            next_cfg[i] = cfg[i];
            if (wr_en && idx == 6'(i)) begin
                next_cfg[i] = PWDATA[7:0];
            end
        end
        next_ram_word = ram_word;
        if (ram_touch) begin
            if (PWRITE) begin
                next_ram_word = PWDATA[7:0];
            end
            // step after every ram access; y by default
            if (x_step) begin
                next_cfg[lds_pkg::IDX_XADDR] = (cfg[lds_pkg::IDX_XADDR] >= lds_pkg::X_LAST) ? 8'h00
                                              : cfg[lds_pkg::IDX_XADDR] + 8'h01;
            end else begin
                next_cfg[lds_pkg::IDX_YADDR] = (cfg[lds_pkg::IDX_YADDR] >= lds_pkg::Y_LAST) ? 8'h00
                                              : cfg[lds_pkg::IDX_YADDR] + 8'h01;
            end
        end
    end

    // registers clear whenever the chip reset pin is low
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < lds_pkg::NUM_CFG; i++) begin
                cfg[i] <= reset_value(i);
            end
            ram_word <= 8'h00;
        end else begin
            for (int i = 0; i < lds_pkg::NUM_CFG; i++) begin
                cfg[i] <= next_cfg[i];
            end
            ram_word <= next_ram_word;
        end
    end

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    logic       partial;      // partial display mode
    logic       fine_osc;     // 32-level oscillator in use
    logic [1:0] duty;         // duty code
    logic [1:0] alt_sel;      // alternation cycle code
    logic [2:0] bias_eff;     // bias after mode override
    logic [6:0] lines_last;   // last scan line of a frame

    assign partial  = cfg[lds_pkg::IDX_MODE][lds_pkg::MODE_PARTIAL];
    // slow oscillator for 4-level grey and partial display
    assign fine_osc = !cfg[lds_pkg::IDX_MODE][lds_pkg::MODE_GREY4] && !partial;
    assign duty     = cfg[lds_pkg::IDX_MODE][lds_pkg::MODE_DUTY_LSB +: 2];
    assign alt_sel  = cfg[lds_pkg::IDX_CONTRAST_ALT][lds_pkg::CA_ALT_LSB +: 2];

    // partial mode overrides the software bias choice
    always_comb begin
        if (partial) begin
            bias_eff = lds_pkg::BIAS_4;
        end else begin
            unique case (cfg[lds_pkg::IDX_CONTRAST_ALT][lds_pkg::CA_BIAS_LSB +: 2])
                2'h0: bias_eff = lds_pkg::BIAS_6;
                2'h1: bias_eff = lds_pkg::BIAS_7;
                2'h2: bias_eff = lds_pkg::BIAS_8;
                2'h3: bias_eff = lds_pkg::BIAS_9;
            endcase
        end
    end

    // frame length in lines; partial display always scans eight
    always_comb begin
        if (partial) begin
            lines_last = 7'd7;
        end else begin
            unique case (duty)
                2'h0: lines_last = 7'd79;
                2'h1: lines_last = 7'd63;
                2'h2: lines_last = 7'd31;
                2'h3: lines_last = 7'd7;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // line timing and alternation
    // ------------------------------------------------------------------
    logic [15:0] div_cnt;        // cycles within a line
    logic [15:0] next_div_cnt;
    logic [6:0]  line;           // scan line
    logic [6:0]  next_line;
    logic [3:0]  alt_cnt;        // lines since last polarity flip
    logic [3:0]  next_alt_cnt;
    logic        polarity;
    logic        next_polarity;
    logic        line_tick;      // one-cycle enable, end of line fetch
    logic [15:0] div_last;
    logic [3:0]  alt_last;       // last alt_cnt value before a flip in line mode

    // the divider rate switches with the oscillator
    assign div_last  = fine_osc ? 16'(FINE_LINE_DIV - 1) : 16'(COARSE_LINE_DIV - 1);
    assign line_tick = (div_cnt >= div_last);

    always_comb begin
        unique case (alt_sel)
            2'h1:    alt_last = 4'd6;
            2'h2:    alt_last = 4'd10;
            default: alt_last = 4'd12;
        endcase
    end

    // line counter and polarity; nothing moves until the release settles
    always_comb begin
        next_div_cnt  = div_cnt;
        next_line     = line;
        next_alt_cnt  = alt_cnt;
        next_polarity = polarity;
        if (rst_sync) begin
            next_div_cnt = line_tick ? 16'h0000 : div_cnt + 16'h0001;
            if (line_tick) begin
                next_line = (line >= lines_last) ? 7'd0 : line + 7'd1;
                if (alt_sel == 2'h0) begin
                    // code zero flips once per frame
                    if (line >= lines_last) begin
                        next_polarity = !polarity;
                    end
                end else if (alt_cnt >= alt_last) begin
                    next_alt_cnt  = 4'h0;
                    next_polarity = !polarity;
                end else begin
                    next_alt_cnt = alt_cnt + 4'h1;
                end
            end
        end
    end

    // held at zero through reset, so the drive does not alternate
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            div_cnt  <= 16'h0000;
            line     <= 7'd0;
            alt_cnt  <= 4'h0;
            polarity <= 1'b0;
        end else begin
            div_cnt  <= next_div_cnt;
            line     <= next_line;
            alt_cnt  <= next_alt_cnt;
            polarity <= next_polarity;
        end
    end

    // ------------------------------------------------------------------
    // host access versus fetch hazard
    // ------------------------------------------------------------------
    logic [7:0] since_access;    // cycles since last ram strobe ended, saturating
    logic [7:0] next_since_access;
    logic       stray;           // a fetch met a recent strobe
    logic       next_stray;

    // only the transfer to the drive is disturbed; ram_word is never touched here
    always_comb begin
        next_since_access = ram_touch ? 8'h00
                          : (since_access == 8'hff) ? since_access : since_access + 8'h01;
        next_stray = line_tick && rst_sync && (since_access < 8'(lds_pkg::HAZARD_CYC));
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            since_access <= 8'hff;
            stray        <= 1'b0;
        end else begin
            since_access <= next_since_access;
            stray        <= next_stray;
        end
    end

    // ------------------------------------------------------------------
    // outputs and read data
    // ------------------------------------------------------------------
    lds_pkg::lds_panel_t next_panel;
    logic [31:0]         next_prdata;
    logic [7:0]          status;

    assign status = {3'h0, stray, polarity, fine_osc, partial, !rst_sync};

    // read data captured in the setup cycle; in reset it reads zero
    always_comb begin
        next_prdata = PRDATA;
        if (setup_ph) begin
            next_prdata = 32'h0000_0000;
            if (mapped && rst_sync) begin
                if (idx == 6'(lds_pkg::IDX_RAM_DATA)) begin
                    next_prdata = {24'h000000, ram_word};
                end else if (idx == 6'(lds_pkg::IDX_STATUS)) begin
                    next_prdata = {24'h000000, status};
                end else begin
                    next_prdata = {24'h000000, cfg[idx[4:0]]};
                end
            end
        end
    end

    // panel drive forced off until the synchronised release
    always_comb begin
        next_panel          = '0;
        next_panel.blank    = !rst_sync || !cfg[lds_pkg::IDX_CTRL][lds_pkg::CTRL_DISP_ON];
        next_panel.polarity = rst_sync && polarity;
        next_panel.partial  = partial;
        next_panel.bias     = bias_eff;
        next_panel.contrast = cfg[lds_pkg::IDX_CONTRAST_ALT][lds_pkg::CA_CONTRAST_LSB +: 3];
        next_panel.line     = line;
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA                <= 32'h0000_0000;
            PANEL                 <= '{blank: 1'b1, default: '0};
            EXT_SUPPLY_ENABLE_OUT <= 1'b0;
            LEVEL_BUFFER_ENABLE   <= 1'b0;
            FINE_GREY_OSC_SELECT  <= 1'b1;
            DISPLAY_ON            <= 1'b0;
            BLINK_ACTIVE          <= 1'b0;
            COLUMN_REVERSED       <= 1'b0;
            STRAY_LINE            <= 1'b0;
        end else begin
            PRDATA                <= next_prdata;
            PANEL                 <= next_panel;
            EXT_SUPPLY_ENABLE_OUT <= cfg[lds_pkg::IDX_CTRL][lds_pkg::CTRL_SUPPLY_ON];
            LEVEL_BUFFER_ENABLE   <= cfg[lds_pkg::IDX_CTRL][lds_pkg::CTRL_LEVEL_BUF];
            FINE_GREY_OSC_SELECT  <= fine_osc;
            DISPLAY_ON            <= cfg[lds_pkg::IDX_CTRL][lds_pkg::CTRL_DISP_ON];
            BLINK_ACTIVE          <= cfg[lds_pkg::IDX_SCAN][lds_pkg::SCAN_BLINK_ON];
            COLUMN_REVERSED       <= cfg[lds_pkg::IDX_SCAN][lds_pkg::SCAN_COL_REV];
            STRAY_LINE            <= stray;
        end
    end

endmodule : lds_ctrl

`default_nettype wire

// *** test/lds_ctrl_props.sv ***
// Purpose: port checks of the lcd reset and supply control block
// Assumes: one clock domain, reset asynchronous and active low
// Notes:   requests count as taken from the third edge after release
`timescale 1ns/1ps
`default_nettype none
module lds_ctrl_props (
    // clock, reset and apb
    input wire logic        SYS_CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA, PRDATA,
    // supply and panel
    input wire logic        EXT_SUPPLY_ENABLE_OUT, LEVEL_BUFFER_ENABLE, FINE_GREY_OSC_SELECT,
    input wire logic        DISPLAY_ON, BLINK_ACTIVE, COLUMN_REVERSED, STRAY_LINE,
    input wire lds_pkg::lds_panel_t PANEL
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // control write that the block really takes, not one still in release
    sequence s_ctrl_taken;
        PSEL && PENABLE && PWRITE && (PADDR == 8'h00) && $past(RESETN, 2);
    endsequence
    a_release_blank: assert property ($rose(RESETN) |->
        PANEL.blank && !PANEL.polarity && !DISPLAY_ON && !BLINK_ACTIVE) else $error("panel live at release");
    a_release_state: assert property ($rose(RESETN) |->
        !EXT_SUPPLY_ENABLE_OUT && !LEVEL_BUFFER_ENABLE && !COLUMN_REVERSED && FINE_GREY_OSC_SELECT
        && PANEL.bias == lds_pkg::BIAS_6 && !PANEL.partial) else $error("state not cleared at release");
    a_supply_follow: assert property (s_ctrl_taken |->
        ##2 EXT_SUPPLY_ENABLE_OUT == $past(PWDATA[0], 2)) else $error("supply pin not following bit");
    a_amp_follow: assert property (s_ctrl_taken |->
        ##2 LEVEL_BUFFER_ENABLE == $past(PWDATA[1], 2)) else $error("buffer enable not following bit");
    a_supply_cause: assert property ($changed(EXT_SUPPLY_ENABLE_OUT) |->
        $past(PSEL && PENABLE && PWRITE && (PADDR == 8'h00), 2)) else $error("supply pin moved alone");
    a_partial_bias: assert property (PANEL.partial |-> PANEL.bias == lds_pkg::BIAS_4)
        else $error("partial mode without quarter bias");
    a_bias_range: assert property (!PANEL.partial |-> PANEL.bias <= lds_pkg::BIAS_9)
        else $error("bias code out of range");
    a_osc_mode: assert property (PANEL.partial |-> !FINE_GREY_OSC_SELECT)
        else $error("fine oscillator in partial mode");
    a_stray_pulse: assert property (STRAY_LINE |=> !STRAY_LINE)
        else $error("stray line longer than a pulse");
endmodule : lds_ctrl_props
bind lds_ctrl lds_ctrl_props i_lds_ctrl_props (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .EXT_SUPPLY_ENABLE_OUT(EXT_SUPPLY_ENABLE_OUT),
    .LEVEL_BUFFER_ENABLE(LEVEL_BUFFER_ENABLE), .FINE_GREY_OSC_SELECT(FINE_GREY_OSC_SELECT),
    .DISPLAY_ON(DISPLAY_ON), .BLINK_ACTIVE(BLINK_ACTIVE), .COLUMN_REVERSED(COLUMN_REVERSED),
    .STRAY_LINE(STRAY_LINE), .PANEL(PANEL));
`default_nettype wire

// *** test/lds_host.sv ***
// Purpose: host processor model on the apb side of the control block
// Assumes: answer may take wait states, pready sampled at rising edges
// Notes:   released address and data show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module lds_host (
    // clock and answer
    input  wire logic        SYS_CLK, PREADY, PSLVERR,
    input  wire logic [31:0] PRDATA,
    // request
    output var  logic        PSEL, PENABLE, PWRITE,
    output var  logic [7:0]  PADDR,
    output var  logic [31:0] PWDATA
);
    logic hang = 1'b0;  // a transfer ran out of its wait bound
    // idle bus at time zero
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {3'h0, 8'h00, 32'h0};
    end
    // one transfer: setup, access held until pready, then release
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {1'b1, 1'b0, wr, a, d};
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        @(posedge SYS_CLK);
        // a busy slave stretches the access like a wait signal
        while (PREADY !== 1'b1 && n < 64) begin
            @(posedge SYS_CLK);
            n++;
        end
        hang = hang || (n >= 64);
        q = PRDATA;
        err = PSLVERR;
        // stale lines would hide a slave that samples too late
        {PSEL, PENABLE, PADDR, PWDATA} <= {1'b0, 1'b0, ~a, ~d};
    endtask : xfer
endmodule : lds_host
`default_nettype wire

// *** test/lds_ctrl_bench.sv ***
// Purpose: self-checking bench of the lcd reset and supply control block
// Assumes: short line dividers so frames and fetches come quickly
// Notes:   outputs are sampled at edges, three edges after the write edge
`timescale 1ns/1ps
`default_nettype none
module lds_ctrl_bench;
    logic sys_clk = 1'b0;  // 40 MHz
    logic resetn = 1'b0;   // held low at start
    logic psel, penable, pwrite, pready, pslverr, ext, lvl, fine, disp, blink, crev, stray;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    lds_pkg::lds_panel_t panel;
    int n_errors = 0;
    int compares = 0;
    int n_stray = 0;  // stray pulses seen
    int s0;
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (stray === 1'b1) n_stray++;
    lds_host i_lds_host (.SYS_CLK(sys_clk), .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata));
    lds_ctrl #(.FINE_LINE_DIV(4), .COARSE_LINE_DIV(8)) i_lds_ctrl (.SYS_CLK(sys_clk), .RESETN(resetn),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .EXT_SUPPLY_ENABLE_OUT(ext), .LEVEL_BUFFER_ENABLE(lvl),
        .FINE_GREY_OSC_SELECT(fine), .PANEL(panel), .DISPLAY_ON(disp), .BLINK_ACTIVE(blink),
        .COLUMN_REVERSED(crev), .STRAY_LINE(stray));
    task automatic results;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, exp, input string what);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        i_lds_host.xfer(w, a, d, q, e);
        if (i_lds_host.hang !== 1'b0) begin
            n_errors++;
            $display("[FAIL] %0t bus hang", $time);
            results();
        end
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        bus(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err, input string what);
        logic [31:0] q;
        logic e;
        bus(1'b0, a, 32'h0, q, e);
        chk(q, exp, what);
        chk(32'(e), 32'(err), what);
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc
    initial begin
        cyc(16);
        resetn <= 1'b1;
        cyc(4);
        chk(32'({panel.blank, panel.polarity, disp, blink, crev, ext, lvl, fine}), 32'h81, "pins");
        for (int i = 0; i < 17; i++) rd(8'(i * 4), 32'h0, 1'b0, "cleared reg");
        wr(8'h44, 32'h5a);
        rd(8'h10, 32'h1, 1'b0, "y stepped");
        rd(8'h0c, 32'h0, 1'b0, "x held");
        rd(8'h4c, 32'h0, 1'b1, "unmapped");
        rd(8'h01, 32'h0, 1'b1, "unaligned");
        wr(8'h08, 32'h7);
        wr(8'h44, 32'h1);
        rd(8'h0c, 32'h1, 1'b0, "x stepped");
        chk(32'({blink, crev}), 32'h3, "scan bits");
        $display("reset values done");
        wr(8'h00, 32'h1);
        cyc(3);
        chk(32'({ext, lvl}), 32'h2, "supply only");
        wr(8'h00, 32'h7);
        cyc(3);
        chk(32'({ext, lvl, disp, panel.blank}), 32'he, "all on");
        wr(8'h00, 32'h4);
        cyc(3);
        chk(32'({ext, lvl, disp}), 32'h1, "supply off");
        $display("supply done");
        for (int b = 0; b < 4; b++) begin
            wr(8'h40, 32'(b * 33 + 1));
            cyc(3);
            chk(32'({panel.bias, panel.contrast}), 32'(b * 9 + 1), "bias");
        end
        wr(8'h40, 32'h0);
        wr(8'h04, 32'h8);
        wr(8'h40, 32'h65);
        cyc(3);
        chk(32'({panel.partial, panel.bias, panel.contrast, fine}), 32'hca, "partial");
        wr(8'h40, 32'h0);
        wr(8'h04, 32'h4);
        cyc(3);
        chk(32'({panel.partial, fine}), 32'h0, "coarse grey");
        wr(8'h04, 32'h0);
        cyc(3);
        chk(32'(fine), 32'h1, "fine grey");
        $display("modes done");
        s0 = n_stray;
        for (int i = 0; i < 24; i++) wr(8'h44, 32'(i));
        chk(32'(n_stray > s0), 32'h1, "stray seen");
        cyc(10);
        s0 = n_stray;
        cyc(40);
        chk(32'(n_stray - s0), 32'h0, "stray idle");
        rd(8'h44, 32'h17, 1'b0, "ram kept");
        $display("flicker done");
        wr(8'h00, 32'h1);
        cyc(3);
        resetn <= 1'b0;
        cyc(2);
        wr(8'h00, 32'h1);
        chk(32'({panel.blank, panel.polarity, ext}), 32'h4, "in reset");
        resetn <= 1'b1;
        cyc(4);
        rd(8'h00, 32'h0, 1'b0, "after reset");
        $display("mid reset done");
        results();
    end
endmodule : lds_ctrl_bench
`default_nettype wire
